/* cs_area_wait_regs.svh */
`ifndef CS_AREA_WAIT_REGS_SVH
`define CS_AREA_WAIT_REGS_SVH

// Wait control word layout
`define WCR_WIDTH         11
`define WCR_WAIT_MSB      10
`define WCR_WAIT_LSB      7
`define WCR_MASK_BIT      6
`define WCR_RSVD_MSB      5
`define WCR_RSVD_LSB      2
`define WCR_HOLD_MSB      1
`define WCR_HOLD_LSB      0

// Reset value: wait code 1010, mask 0, hold 00
`define WCR_RESET         11'h500
`define WCR_WRITE_MASK    11'h7C3

// Timing: one bus cycle is two sys_clk ticks
`define TICKS_PER_CYCLE   2
`define TICK_CNT_WIDTH    6
`define STROBE_BASE_TICKS 2

`endif

/* cs_area_wait_pkg.sv */
package cs_area_wait_pkg;

  // Access sequencer states, Gray coded around the loop
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_STROBE  = 2'b01,
    ST_EXTWAIT = 2'b11,
    ST_HOLD    = 2'b10
  } state_type;

  typedef logic [4:0] wait_cycles_type;
  typedef logic [1:0] hold_code_type;

endpackage

/* down_tick_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module down_tick_counter #(
  parameter int WIDTH = 6
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  output var  logic [WIDTH-1:0] count,
  output var  logic             atZero
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;

  // Load wins, otherwise count down to zero and stop
  assign count_next = load ? loadValue
                    : (count_reg == '0) ? count_reg
                    : count_reg - WIDTH'(1);
  assign count      = count_reg;
  assign atZero     = (count_reg == '0);

  // Counter register, frozen while the clock enable is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (clkEn) begin
      count_reg <= count_next;
    end
  end

endmodule

`default_nettype wire

/* cs_area_wait_hold.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cs_area_wait_regs.svh"

module cs_area_wait_hold (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    clkEn,
  input  wire logic                    cfgWrite,
  input  wire logic [`WCR_WIDTH-1:0]   cfgWriteData,
  output var  logic [`WCR_WIDTH-1:0]   cfgReadData,
  input  wire logic                    accessReq,
  input  wire logic                    accessWrite,
  input  wire logic                    extWaitN,
  output var  logic                    accessBusy,
  output var  logic                    accessDone,
  output var  logic                    chip_select_n,
  output var  logic                    readStrobeN,
  output var  logic                    byte_lane_strobe_n,
  output var  logic                    addrDrive,
  output var  cs_area_wait_pkg::state_type accessState
);
  import cs_area_wait_pkg::*;

  logic [`WCR_WIDTH-1:0]      waitCtrl_reg;
  logic [`WCR_WIDTH-1:0]      waitCtrl_next;
  state_type                  state_reg;
  state_type                  state_next;
  logic                       isWrite_reg;
  logic                       chipSelectN_reg;
  logic                       chipSelectN_next;
  logic                       readStrobeN_reg;
  logic                       readStrobeN_next;
  logic                       byteStrobeN_reg;
  logic                       byteStrobeN_next;
  logic                       done_reg;
  logic                       done_next;
  logic [3:0]                 access_wait_code;
  logic                       ext_wait_input_mask;
  hold_code_type              hold_delay_code;
  wait_cycles_type            waitCycles;
  logic                       startAccess;
  logic                       strobeEnd;
  logic                       waitActive;
  logic                       cntLoad;
  logic [`TICK_CNT_WIDTH-1:0] cntLoadValue;
  logic                       cntZero;

  // Field views of the control word
  assign access_wait_code    = waitCtrl_reg[`WCR_WAIT_MSB:`WCR_WAIT_LSB];
  assign ext_wait_input_mask = waitCtrl_reg[`WCR_MASK_BIT];
  assign hold_delay_code     = waitCtrl_reg[`WCR_HOLD_MSB:`WCR_HOLD_LSB];

  // Wait code decode in bus cycles; reserved codes fall to the longest count
  always_comb begin
    case (access_wait_code)
      4'h0:    waitCycles = 5'h00;
      4'h1:    waitCycles = 5'h01;
      4'h2:    waitCycles = 5'h02;
      4'h3:    waitCycles = 5'h03;
      4'h4:    waitCycles = 5'h04;
      4'h5:    waitCycles = 5'h05;
      4'h6:    waitCycles = 5'h06;
      4'h7:    waitCycles = 5'h08;
      4'h8:    waitCycles = 5'h0A;
      4'h9:    waitCycles = 5'h0C;
      4'hA:    waitCycles = 5'h0E;
      4'hB:    waitCycles = 5'h12;
      4'hC:    waitCycles = 5'h18;
      default: waitCycles = 5'h18;
    endcase
  end

  // Reserved bits are never stored so they read back as zero
  assign waitCtrl_next = cfgWrite ? (cfgWriteData & `WCR_WRITE_MASK) : waitCtrl_reg;

  // Sequencer decode
  assign startAccess = (state_reg == ST_IDLE) && accessReq;
  assign waitActive  = !ext_wait_input_mask && !extWaitN;
  assign strobeEnd   = (state_reg == ST_STROBE) && cntZero;
  assign cntLoad     = startAccess || (strobeEnd && !waitActive)
                     || ((state_reg == ST_EXTWAIT) && !waitActive);
  // Strobe phase is 2w+2 ticks; hold phase is 2h+1 ticks (half-cycle steps)
  assign cntLoadValue = startAccess ? {waitCycles, 1'b1}
                      : {3'h0, hold_delay_code, 1'b0};

  // Next state and pin levels
  always_comb begin
    state_next       = state_reg;
    chipSelectN_next = chipSelectN_reg;
    readStrobeN_next = readStrobeN_reg;
    byteStrobeN_next = byteStrobeN_reg;
    done_next        = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (accessReq) begin
          state_next       = ST_STROBE;
          chipSelectN_next = 1'b0;
          readStrobeN_next = accessWrite;
          byteStrobeN_next = !accessWrite;
        end
      end
      ST_STROBE: begin
        if (cntZero) begin
          if (waitActive) begin
            state_next = ST_EXTWAIT;
          end else begin
            state_next       = ST_HOLD;
            readStrobeN_next = 1'b1;
            byteStrobeN_next = 1'b1;
          end
        end
      end
      ST_EXTWAIT: begin
        if (!waitActive) begin
          state_next       = ST_HOLD;
          readStrobeN_next = 1'b1;
          byteStrobeN_next = 1'b1;
        end
      end
      ST_HOLD: begin
        if (cntZero) begin
          state_next       = ST_IDLE;
          chipSelectN_next = 1'b1;
          done_next        = 1'b1;
        end
      end
      default: begin
        state_next       = ST_IDLE;
        chipSelectN_next = 1'b1;
        readStrobeN_next = 1'b1;
        byteStrobeN_next = 1'b1;
      end
    endcase
  end

  // Tick counter shared by strobe and hold phases
  down_tick_counter #(
    .WIDTH (`TICK_CNT_WIDTH)
  ) u_tick_counter (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clkEn     (clkEn),
    .load      (cntLoad),
    .loadValue (cntLoadValue),
    .count     (),
    .atZero    (cntZero)
  );

  // Control word register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCtrl_reg <= `WCR_RESET;
    end else if (clkEn) begin
      waitCtrl_reg <= waitCtrl_next;
    end
  end

  // Sequencer and pin registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= ST_IDLE;
      chipSelectN_reg <= 1'b1;
      readStrobeN_reg <= 1'b1;
      byteStrobeN_reg <= 1'b1;
      done_reg        <= 1'b0;
      isWrite_reg     <= 1'b0;
    end else if (clkEn) begin
      state_reg       <= state_next;
      chipSelectN_reg <= chipSelectN_next;
      readStrobeN_reg <= readStrobeN_next;
      byteStrobeN_reg <= byteStrobeN_next;
      done_reg        <= done_next;
      isWrite_reg     <= startAccess ? accessWrite : isWrite_reg;
    end
  end

  // Outputs straight from flip-flops
  assign cfgReadData        = waitCtrl_reg;
  assign accessState        = state_reg;
  assign accessBusy         = !chipSelectN_reg;
  assign addrDrive          = !chipSelectN_reg;
  assign chip_select_n      = chipSelectN_reg;
  assign readStrobeN        = readStrobeN_reg;
  assign byte_lane_strobe_n = byteStrobeN_reg;
  assign accessDone         = done_reg;

  // Helper logic for checks: latched settings and ticks spent in a phase
  logic [4:0] latWait_reg;
  logic [1:0] latHold_reg;
  logic [6:0] phaseTicks_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latWait_reg    <= 5'h00;
      latHold_reg    <= 2'h0;
      phaseTicks_reg <= 7'h00;
    end else if (clkEn) begin
      latWait_reg    <= startAccess ? waitCycles : latWait_reg;
      latHold_reg    <= (state_next == ST_HOLD && state_reg != ST_HOLD)
                        ? hold_delay_code : latHold_reg;
      phaseTicks_reg <= (state_next != state_reg) ? 7'h00 : phaseTicks_reg + 7'h01;
    end
  end

  // Checks
  chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfgReadData[`WCR_RSVD_MSB:`WCR_RSVD_LSB] == 4'h0)
    else $error("reserved control bits read nonzero");
  chk_reset_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !$past(rst_n) |-> cfgReadData == `WCR_RESET)
    else $error("control word reset value wrong");
  chk_strobe_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && strobeEnd) |-> ({2'h0, phaseTicks_reg} + 9'h001) == ({4'h0, latWait_reg} * 9'h002 + 9'h002))
    else $error("strobe phase length wrong");
  chk_hold_length: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && state_reg == ST_HOLD && cntZero) |->
      (phaseTicks_reg + 7'h01) == ({4'h0, latHold_reg, 1'b0} + 7'h01))
    else $error("hold phase length wrong");
  chk_mask_ignores: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && strobeEnd && ext_wait_input_mask) |=> state_reg == ST_HOLD)
    else $error("masked wait input extended access");
  chk_wait_honoured: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && strobeEnd && !ext_wait_input_mask && !extWaitN) |=>
      state_reg == ST_EXTWAIT && (!readStrobeN_reg || !byteStrobeN_reg))
    else $error("wait input not honoured");
  chk_wait_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && state_reg == ST_EXTWAIT && extWaitN) |=>
      state_reg == ST_HOLD && readStrobeN_reg && byteStrobeN_reg && !chip_select_n)
    else $error("wait release did not enter hold");
  chk_cs_covers_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!readStrobeN_reg || !byteStrobeN_reg) |-> !chipSelectN_reg)
    else $error("strobe active without chip select");
  chk_done_ends_cs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(done_reg) |-> chipSelectN_reg && $past(state_reg) == ST_HOLD)
    else $error("done without hold end");

  cov_zero_wait: cover property (@(posedge sys_clk) disable iff (!rst_n)
    startAccess && clkEn && waitCycles == 5'h00);
  cov_ext_wait: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ST_EXTWAIT);
  cov_long_hold: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg == ST_HOLD && latHold_reg == 2'h3);
  cov_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
    !byteStrobeN_reg && isWrite_reg);

endmodule

`default_nettype wire

/* sram_wait_partner.sv */
`timescale 1ns/1ps
`default_nettype none

// Far-side memory: holds the wait line low for waitLen strobe ticks
module sram_wait_partner (
  input  wire logic       sys_clk,
  input  wire logic       chip_select_n,
  input  wire logic       readStrobeN,
  input  wire logic       byte_lane_strobe_n,
  input  wire logic [7:0] waitLen,
  output var  logic       extWaitN
);
  logic [7:0] strobeCount = 8'h00;
  wire  logic strobeLow = !chip_select_n && (!readStrobeN || !byte_lane_strobe_n);

  // Counts strobe ticks on the falling edge, clears between accesses
  always @(negedge sys_clk) begin
    strobeCount <= strobeLow ? strobeCount + 8'h01 : 8'h00;
  end

  // Line has a pull-up, so it reads high whenever the memory lets go
  assign extWaitN = !(strobeLow && (strobeCount < waitLen));
endmodule

`default_nettype wire

/* cs_area_wait_hold_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cs_area_wait_regs.svh"

module cs_area_wait_hold_tb;
  import cs_area_wait_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n, clkEn, cfgWrite, accessReq, accessWrite;
  logic [10:0] cfgWriteData, cfgReadData;
  logic [7:0]  waitLen;
  logic        extWaitN, accessBusy, accessDone, chip_select_n;
  logic        readStrobeN, byte_lane_strobe_n, addrDrive;
  state_type   accessState;
  int          failures = 0;
  int          comparisons = 0;
  int          testNum = 0;
  logic [3:0]  codes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
                              4'hA, 4'hB, 4'hC};
  int          cycles [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};

  always #5 sys_clk = ~sys_clk;

  cs_area_wait_hold DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn),
    .cfgWrite(cfgWrite), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
    .accessReq(accessReq), .accessWrite(accessWrite), .extWaitN(extWaitN),
    .accessBusy(accessBusy), .accessDone(accessDone), .chip_select_n(chip_select_n),
    .readStrobeN(readStrobeN), .byte_lane_strobe_n(byte_lane_strobe_n),
    .addrDrive(addrDrive), .accessState(accessState));

  sram_wait_partner far (.sys_clk(sys_clk), .chip_select_n(chip_select_n),
    .readStrobeN(readStrobeN), .byte_lane_strobe_n(byte_lane_strobe_n),
    .waitLen(waitLen), .extWaitN(extWaitN));

  // Compares one value and counts it
  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run
  task report_and_stop;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Control word write, one enabled edge
  task cfg_write(input logic [10:0] data);
    @(negedge sys_clk);
    cfgWrite = 1'b1;
    cfgWriteData = data;
    @(negedge sys_clk);
    cfgWrite = 1'b0;
  endtask

  // One access; counts strobe-low ticks and hold ticks with chip select still low
  task access(input logic wr, input int frz, output int sLow, output int hLow);
    int   guard;
    logic strobe;
    sLow = 0;
    hLow = 0;
    guard = 0;
    @(negedge sys_clk);
    accessReq = 1'b1;
    accessWrite = wr;
    @(negedge sys_clk);
    accessReq = 1'b0;
    check({chip_select_n, addrDrive, accessBusy}, 16'h0003);
    if (frz > 0) clkEn = 1'b0;
    while (accessDone !== 1'b1 && guard < 200) begin
      if (frz > 0 && guard == frz) clkEn = 1'b1;
      strobe = wr ? byte_lane_strobe_n : readStrobeN;
      if (strobe === 1'b0) sLow++;
      else if (chip_select_n === 1'b0) hLow++;
      @(negedge sys_clk);
      guard++;
    end
    check({chip_select_n, addrDrive, accessBusy}, 16'h0004);
    check(accessState, ST_IDLE);
    @(negedge sys_clk);
    check(accessDone, 16'h0000);
  endtask

  // Programs the word, runs one access and checks both phase lengths
  task run(input int i, input logic m, input logic [1:0] h, input logic wr,
           input int l, input int frz);
    int s, hl, e;
    waitLen = l[7:0];
    cfg_write({codes[i], m, 4'h0, h});
    e = 2 * cycles[i] + 2;
    if (!m && l > e) e = l;
    access(wr, frz, s, hl);
    check(s, e + frz);
    check(hl, 2 * h + 1);
    testNum++;
    $display("Test %0d finished", testNum);
  endtask

  // Main sequence
  initial begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    cfgWrite = 1'b0;
    cfgWriteData = 11'h000;
    accessReq = 1'b0;
    accessWrite = 1'b0;
    waitLen = 8'h00;
    repeat (2) @(negedge sys_clk);
    check(cfgReadData, 11'h500);
    check({chip_select_n, readStrobeN, byte_lane_strobe_n}, 16'h0007);
    rst_n = 1'b1;
    // Reserved bits are always written as zero, reserved wait codes never loaded
    cfg_write(11'h3C3);
    check(cfgReadData, 11'h3C3);
    // Every defined wait code, none of the reserved ones
    for (int i = 0; i < 13; i++) run(i, 1'b1, 2'h0, 1'b0, 0, 0);
    for (int h = 0; h < 4; h++) run(0, 1'b1, h[1:0], 1'b0, 0, 0);
    run(1, 1'b1, 2'h1, 1'b1, 0, 0);
    run(0, 1'b1, 2'h0, 1'b0, 5, 0);
    run(0, 1'b0, 2'h0, 1'b0, 5, 0);
    run(2, 1'b0, 2'h3, 1'b0, 9, 0);
    run(2, 1'b0, 2'h2, 1'b1, 3, 0);
    run(3, 1'b1, 2'h0, 1'b0, 30, 0);
    run(0, 1'b1, 2'h0, 1'b0, 0, 3);
    report_and_stop;
  end

  // Watchdog against a hung access
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
endmodule

`default_nettype wire
